/* design/lbd_channel.sv */
// Purpose: one LED output gate with its phase offset
// Assumes: shared period counter in 20 MHz ticks
// Notes:   offset is a fraction of the period, fixed after init
`timescale 1ns/1ps
`default_nettype none
module lbd_channel
  import lbd_pkg::*;
(
  input  wire logic             clock_i,   // system clock
  input  wire logic             rst_n_i,   // async reset, low
  input  wire logic             ce_i,      // clock enable
  input  wire logic [PER_W-1:0] cnt_i,     // period position
  input  wire logic [PER_W:0]   period_i,  // period length in ticks
  input  wire logic [15:0]      frac_i,    // phase offset fraction
  input  wire logic             active_i,  // output in use
  input  wire logic             direct_i,  // follow input level
  input  wire logic             level_i,   // synced input level
  input  wire logic [PER_W:0]   on_len_i,  // pulse length in ticks
  output logic                  gate_o     // registered gate
);
  logic [PER_W+16:0] prod;
  logic [PER_W:0]    offs;
  logic [PER_W:0]    pos;

  assign prod = period_i * frac_i;
  assign offs = prod[PER_W+16:16];
  assign pos  = ({1'b0, cnt_i} >= offs) ? {1'b0, cnt_i} - offs
                                        : {1'b0, cnt_i} + period_i - offs;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_o <= 1'b0;
    end else if (ce_i) begin
      if (direct_i) begin
        gate_o <= active_i & level_i;
      end else begin
        gate_o <= active_i && (pos < on_len_i);
      end
    end
  end
endmodule
`default_nettype wire

/* design/lbd_core.sv */
// Purpose: brightness path and six-output PWM dimming engine
// Assumes: APB register access, straps sampled once after reset
// Notes:   all state freezes while ce_i is low, APB answers included
`timescale 1ns/1ps
`default_nettype none

module lbd_core
  import lbd_pkg::*;
(
  input  wire logic        clock_i,       // 125 MHz clock
  input  wire logic        rst_n_i,       // async reset, low
  input  wire logic        ce_i,          // clock enable
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB access phase
  input  wire logic        pwrite,        // APB direction
  input  wire logic [7:0]  paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic             pready,        // APB ready
  output logic      [31:0] prdata,        // APB read data
  output logic             pslverr,       // APB error
  input  wire logic        pwm_in_i,      // host PWM pin
  input  wire logic [2:0]  mode_strap_i,  // mode strap code
  input  wire logic [2:0]  led_freq_strap_i,    // frequency strap code
  input  wire logic [2:0]  string_layout_strap_i, // layout strap code
  output logic [NCH-1:0]   led_gate_o,    // per-output PWM gate
  output logic [11:0]      current_scale_o, // analog current level
  output logic [6:0]       serial_addr_o, // decoded serial address
  output logic             init_done_o    // straps captured
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [9:0] sy1_r, sy2_r, sy3_r;
  logic       pwm_lvl_r;
  logic [8:0] strap_q;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sy1_r <= '0;
      sy2_r <= '0;
      sy3_r <= '0;
    end else if (ce_i) begin
      sy1_r <= {string_layout_strap_i, led_freq_strap_i, mode_strap_i,
                pwm_in_i};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_lvl_r <= 1'b0;
    end else if (ce_i && (sy2_r[0] == sy3_r[0])) begin
      pwm_lvl_r <= sy3_r[0];
    end
  end
  assign strap_q = sy3_r[9:1];

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  lbd_cfg_t   cfg_r;
  logic [2:0] init_cnt_r;
  logic       init_done_r;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r       <= '0;
      init_cnt_r  <= '0;
      init_done_r <= 1'b0;
    end else if (ce_i && !init_done_r) begin
      if (init_cnt_r != 3'(INIT_WAIT)) begin
        init_cnt_r <= init_cnt_r + 3'd1;
      end else if (sy2_r[9:1] == sy3_r[9:1]) begin
        cfg_r.mode     <= lbd_mode_t'(strap_q[1:0]);
        cfg_r.addr_low <= strap_q[2];
        cfg_r.freq     <= strap_q[5:3];
        cfg_r.layout   <= strap_q[8:6];
        init_done_r    <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  logic [2:0]  ctrl_r;
  logic [2:0]  slope_r;
  logic [3:0]  dither_r;
  logic [15:0] reg_bright_r;
  logic [15:0] cur_r;
  logic        acc_ph;
  logic        hit;
  logic [31:0] rd_val;

  assign acc_ph = psel && penable && !pready;

  always_comb begin
    hit    = 1'b1;
    rd_val = '0;
    unique case (paddr)
      OFS_CTRL:   rd_val = {29'h0, ctrl_r};
      OFS_SLOPE:  rd_val = {29'h0, slope_r};
      OFS_DITHER: rd_val = {28'h0, dither_r};
      OFS_BRIGHT: rd_val = {16'h0, reg_bright_r};
      OFS_STATUS: rd_val = {6'h0, init_done_r, cfg_r, cur_r};
      default:    hit    = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (ce_i) begin
      pready  <= acc_ph;
      pslverr <= acc_ph && !hit;
      prdata  <= (acc_ph && !pwrite) ? rd_val : 32'h0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r       <= CTRL_RST;
      slope_r      <= SLOPE_RST;
      dither_r     <= DITHER_RST;
      reg_bright_r <= BRIGHT_RST;
    end else if (ce_i && acc_ph && pwrite) begin
      unique case (paddr)
        OFS_CTRL:   ctrl_r       <= pwdata[2:0];
        OFS_SLOPE:  slope_r      <= pwdata[2:0];
        OFS_DITHER: dither_r     <= pwdata[3:0];
        OFS_BRIGHT: reg_bright_r <= pwdata[15:0];
        default:    ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // input duty measurement
  // ----------------------------------------------------------------
  logic [MEAS_W-1:0] on_cnt_r, per_cnt_r, last_on_r;
  logic              lvl_d_r;
  logic              div_start_r;
  logic [MEAS_W-1:0] div_den_r;
  logic [MEAS_W-1:0] on_diff;
  logic              div_done;
  logic [39:0]       div_quo;
  logic [15:0]       pwm_bright_r;
  logic              rise;
  logic              per_sat;

  assign rise    = pwm_lvl_r && !lvl_d_r;
  assign per_sat = &per_cnt_r;
  assign on_diff = (on_cnt_r > last_on_r) ? on_cnt_r - last_on_r
                                          : last_on_r - on_cnt_r;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_d_r      <= 1'b0;
      on_cnt_r     <= '0;
      per_cnt_r    <= '0;
      last_on_r    <= '0;
      div_start_r  <= 1'b0;
      div_den_r    <= '0;
      pwm_bright_r <= '0;
    end else if (ce_i) begin
      lvl_d_r     <= pwm_lvl_r;
      div_start_r <= 1'b0;
      if (rise) begin
        on_cnt_r  <= MEAS_W'(1); // rise cycle is already high
        per_cnt_r <= MEAS_W'(1);
        if (on_diff > MEAS_W'(HYST_CYC)) begin
          last_on_r   <= on_cnt_r;
          div_den_r   <= per_cnt_r;
          div_start_r <= 1'b1;
        end
      end else if (per_sat) begin
        pwm_bright_r <= pwm_lvl_r ? BR_FULL : 16'h0;
      end else begin
        per_cnt_r <= per_cnt_r + 1'b1;
        if (pwm_lvl_r) begin
          on_cnt_r <= on_cnt_r + 1'b1;
        end
      end
      if (div_done) begin
        pwm_bright_r <= (|div_quo[39:16]) ? BR_FULL : div_quo[15:0];
      end
    end
  end

  lbd_divider #(.NW(40), .DW(MEAS_W)) u_div (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .start_i (div_start_r),
    .num_i   ({last_on_r, 16'h0}),
    .den_i   (div_den_r),
    .done_o  (div_done),
    .quo_o   (div_quo)
  );

  // ----------------------------------------------------------------
  // sloper
  // ----------------------------------------------------------------
  logic [15:0] target;
  logic [15:0] gap;
  logic [12:0] step_cnt_r;
  logic [12:0] step_lim;
  int          step_cyc;

  assign target = ctrl_r[CTRL_SRC] ? reg_bright_r : pwm_bright_r;
  assign gap    = (target > cur_r) ? target - cur_r : cur_r - target;

  always_comb begin
    step_cyc = slope_ms(slope_r) * (CLK_HZ / 1000) / STEP_FULL;
    step_lim = 13'(step_cyc);
    if (ctrl_r[CTRL_SMOOTH] && (gap < SMOOTH_BAND)) begin
      step_lim = 13'(step_cyc * 2);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_r      <= '0;
      step_cnt_r <= '0;
    end else if (ce_i) begin
      if (slope_r == 3'h0) begin
        cur_r <= target;
      end else if (cur_r != target) begin
        if (step_cnt_r >= step_lim - 13'd1) begin
          step_cnt_r <= '0;
          cur_r <= (target > cur_r) ? cur_r + 16'd1 : cur_r - 16'd1;
        end else begin
          step_cnt_r <= step_cnt_r + 13'd1;
        end
      end else begin
        step_cnt_r <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode mapping to duty and current
  // ----------------------------------------------------------------
  logic [15:0] duty_b;
  logic [15:0] curr_b;
  logic [15:0] thr;

  always_comb begin
    thr    = ctrl_r[CTRL_THR0] ? 16'h0 : HYB_THR;
    duty_b = BR_FULL;
    curr_b = BR_FULL;
    unique case (cfg_r.mode)
      MODE_PHASE:   duty_b = cur_r;
      MODE_HYBRID: begin
        if (cur_r < thr) begin
          duty_b = 16'(cur_r << HYB_SHIFT);
          curr_b = thr;
        end else begin
          curr_b = cur_r;
        end
      end
      MODE_CURRENT: curr_b = cur_r;
      MODE_DIRECT:  duty_b = BR_FULL;
    endcase
  end

  // ----------------------------------------------------------------
  // dimming period, dither and pulse skipping
  // ----------------------------------------------------------------
  logic [7:0]       osc_acc_r;
  logic             tick;
  logic [PER_W-1:0] cnt_r;
  logic [PER_W:0]   period;
  logic [PER_W:0]   on_len_r;
  logic [20:0]      scaled;
  logic [PER_W:0]   base;
  logic [3:0]       frac_d;
  logic [2:0]       dsel;
  logic [3:0]       dmask;
  logic [3:0]       frame_r;
  logic [PER_W:0]   len;
  logic [PER_W:0]   skip_acc_r;
  logic [7:0]       skip_cnt_r;
  logic [7:0]       skip_max;
  logic             wrap;

  assign tick   = (osc_acc_r + OSC_INC) >= OSC_MOD;
  assign period = (PER_W+1)'(1) << (PER_W - int'(cfg_r.freq));
  assign wrap   = tick && ({1'b0, cnt_r} == period - 1'b1);
  assign scaled = {duty_b, 5'h0} >> cfg_r.freq;
  assign base   = {1'b0, scaled[20:4]};
  assign dsel   = (dither_r > 4'(DITH_MAX)) ? 3'(DITH_MAX) : dither_r[2:0];
  assign frac_d = scaled[3:0] >> (3'(DITH_MAX) - dsel);
  assign dmask  = 4'((5'h1 << dsel) - 5'h1);
  assign skip_max = 8'((9'h1 << cfg_r.freq) - 9'h1);

  always_comb begin
    len = base;
    if (duty_b == BR_FULL) begin
      len = period;
    end else if ((frame_r & dmask) < frac_d) begin
      len = base + 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_acc_r <= '0;
      cnt_r     <= '0;
    end else if (ce_i) begin
      osc_acc_r <= tick ? osc_acc_r + OSC_INC - OSC_MOD
                        : osc_acc_r + OSC_INC;
      if (wrap) begin
        cnt_r <= '0;
      end else if (tick) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_len_r   <= '0;
      frame_r    <= '0;
      skip_acc_r <= '0;
      skip_cnt_r <= '0;
    end else if (ce_i && wrap) begin
      frame_r <= frame_r + 4'd1;
      if (len == '0 || len >= (PER_W+1)'(MIN_TICKS)) begin
        on_len_r   <= len;
        skip_acc_r <= '0;
        skip_cnt_r <= '0;
      end else if (skip_acc_r + len >= (PER_W+1)'(MIN_TICKS) ||
                   skip_cnt_r >= skip_max) begin
        on_len_r   <= (PER_W+1)'(MIN_TICKS);
        skip_acc_r <= (skip_acc_r + len >= (PER_W+1)'(MIN_TICKS))
                    ? skip_acc_r + len - (PER_W+1)'(MIN_TICKS) : '0;
        skip_cnt_r <= '0;
      end else begin
        on_len_r   <= '0;
        skip_acc_r <= skip_acc_r + len;
        skip_cnt_r <= skip_cnt_r + 8'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // output channels and status outputs
  // ----------------------------------------------------------------
  logic direct;
  assign direct = cfg_r.mode == MODE_DIRECT;

  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    logic [15:0] frac;
    logic        active;
    assign frac   = 16'(chan_phase(cfg_r.layout, ch) * STEP_FULL /
                        num_phases(cfg_r.layout));
    assign active = init_done_r && ((cfg_r.layout > 3'h4) ||
                    (ch < num_phases(cfg_r.layout)));
    lbd_channel u_ch (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_i),
      .ce_i     (ce_i),
      .cnt_i    (cnt_r),
      .period_i (period),
      .frac_i   (frac),
      .active_i (active),
      .direct_i (direct),
      .level_i  (pwm_lvl_r),
      .on_len_i (on_len_r),
      .gate_o   (led_gate_o[ch])
    );
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      current_scale_o <= '0;
      serial_addr_o   <= ADDR_HIGH;
      init_done_o     <= 1'b0;
    end else if (ce_i) begin
      current_scale_o <= init_done_r ? curr_b[15:4] : 12'h0;
      serial_addr_o   <= cfg_r.addr_low ? ADDR_LOW : ADDR_HIGH;
      init_done_o     <= init_done_r;
    end
  end

endmodule
`default_nettype wire

/* design/lbd_divider.sv */
// Purpose: serial restoring divider for input duty measurement
// Assumes: one quotient bit per enabled clock
// Notes:   done pulses one cycle; start while busy is ignored
`timescale 1ns/1ps
`default_nettype none
module lbd_divider #(
  parameter int NW = 40,
  parameter int DW = 24
) (
  input  wire logic          clock_i,  // system clock
  input  wire logic          rst_n_i,  // async reset, low
  input  wire logic          ce_i,     // clock enable
  input  wire logic          start_i,  // begin a division
  input  wire logic [NW-1:0] num_i,    // dividend
  input  wire logic [DW-1:0] den_i,    // divisor
  output logic               done_o,   // quotient valid pulse
  output logic      [NW-1:0] quo_o     // quotient
);
  logic [NW-1:0] quo_r;
  logic [DW:0]   rem_r;
  logic [DW-1:0] den_r;
  logic [6:0]    cnt_r;
  logic          busy_r;
  logic          done_r;
  logic [DW:0]   trial;

  assign trial  = {rem_r[DW-1:0], quo_r[NW-1]};
  assign done_o = done_r;
  assign quo_o  = quo_r;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quo_r  <= '0;
      rem_r  <= '0;
      den_r  <= '0;
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce_i) begin
      done_r <= 1'b0;
      if (!busy_r && start_i) begin
        quo_r  <= num_i;
        rem_r  <= '0;
        den_r  <= den_i;
        cnt_r  <= 7'(NW);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (trial >= {1'b0, den_r}) begin
          rem_r <= trial - {1'b0, den_r};
          quo_r <= {quo_r[NW-2:0], 1'b1};
        end else begin
          rem_r <= trial;
          quo_r <= {quo_r[NW-2:0], 1'b0};
        end
        cnt_r <= cnt_r - 7'd1;
        if (cnt_r == 7'd1) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* design/lbd_pkg.sv */
// Purpose: shared constants, types and decode helpers of the dimming core
// Assumes: 125 MHz system clock; a 20 MHz dimming tick is derived from it
// Notes:   slope and layout tables live here as functions
package lbd_pkg;

  // ----------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 125_000_000;
  localparam int OSC_HZ       = 20_000_000;
  localparam int MHZ          = 1_000_000;
  localparam logic [7:0] OSC_INC = 8'(OSC_HZ / MHZ);
  localparam logic [7:0] OSC_MOD = 8'(CLK_HZ / MHZ);
  localparam int HYST_NS      = 6400;
  localparam int HYST_CYC     = HYST_NS * (CLK_HZ / MHZ) / 1000;
  localparam int MIN_PULSE_NS = 200;
  localparam int MIN_TICKS    = (MIN_PULSE_NS * (OSC_HZ / MHZ) + 999) / 1000;
  localparam int INIT_WAIT    = 4;
  localparam int STEP_FULL    = 65536;

  // ----------------------------------------------------------------
  // widths and levels
  // ----------------------------------------------------------------
  localparam int NCH    = 6;
  localparam int BR_W   = 16;
  localparam int PER_W  = 17;
  localparam int MEAS_W = 24;
  localparam int DITH_MAX = 4;
  localparam logic [15:0] BR_FULL     = 16'hffff;
  localparam logic [15:0] HYB_THR     = 16'h2000;
  localparam logic [15:0] SMOOTH_BAND = 16'h2000;
  localparam int HYB_SHIFT = 3;
  localparam logic [6:0] ADDR_HIGH = 7'h2b;
  localparam logic [6:0] ADDR_LOW  = 7'h2a;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SLOPE  = 8'h04;
  localparam logic [7:0] OFS_DITHER = 8'h08;
  localparam logic [7:0] OFS_BRIGHT = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam int CTRL_SRC    = 0;
  localparam int CTRL_SMOOTH = 1;
  localparam int CTRL_THR0   = 2;
  localparam logic [2:0]  CTRL_RST   = 3'h2;
  localparam logic [2:0]  SLOPE_RST  = 3'h3;
  localparam logic [3:0]  DITHER_RST = 4'h0;
  localparam logic [15:0] BRIGHT_RST = 16'h0000;

  typedef enum logic [1:0] {
    MODE_PHASE, MODE_HYBRID, MODE_CURRENT, MODE_DIRECT
  } lbd_mode_t;

  typedef struct packed {
    lbd_mode_t  mode;
    logic       addr_low;
    logic [2:0] freq;
    logic [2:0] layout;
  } lbd_cfg_t;

  // full-scale ramp time in ms per slope code
  function automatic int slope_ms(input logic [2:0] sel);
    case (sel)
      3'h1:    slope_ms = 50;
      3'h2:    slope_ms = 100;
      3'h3:    slope_ms = 200;
      3'h4:    slope_ms = 300;
      3'h5:    slope_ms = 500;
      3'h6:    slope_ms = 1000;
      default: slope_ms = 2000;
    endcase
  endfunction

  function automatic int num_phases(input logic [2:0] lay);
    case (lay)
      3'h0: num_phases = 6;
      3'h1: num_phases = 5;
      3'h2: num_phases = 4;
      3'h3: num_phases = 3;
      3'h4: num_phases = 2;
      3'h5: num_phases = 3;
      3'h6: num_phases = 2;
      default: num_phases = 1;
    endcase
  endfunction

  // phase slot of one output; grouped layouts share a slot
  function automatic int chan_phase(input logic [2:0] lay, input int ch);
    case (lay)
      3'h5:    chan_phase = ch / 2;
      3'h6:    chan_phase = ch / 3;
      3'h7:    chan_phase = 0;
      default: chan_phase = ch;
    endcase
  endfunction

endpackage

/* test/lbd_core_chk.sv */
// Purpose: port assertions for lbd_core
// Assumes: straps held until init_done_o rises
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module lbd_core_chk
  import lbd_pkg::*;
(
  input wire logic           clock_i,     // clock
  input wire logic           rst_n_i,     // reset, low
  input wire logic           ce_i,        // clock enable
  input wire logic           psel,        // apb select
  input wire logic           penable,     // apb access
  input wire logic           pready,      // apb ready
  input wire logic           pslverr,     // apb error
  input wire logic           pwm_in_i,    // host pwm
  input wire logic [2:0]     mode_strap_i, // mode strap
  input wire logic [2:0]     string_layout_strap_i, // layout strap
  input wire logic [NCH-1:0] led_gate_o,  // gates
  input wire logic [11:0]    current_scale_o, // current level
  input wire logic [6:0]     serial_addr_o, // address
  input wire logic           init_done_o  // straps taken
);
  logic [1:0] md_r;
  logic [2:0] lay_r;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      md_r  <= 2'h0;
      lay_r <= 3'h0;
    end else if (!init_done_o) begin
      md_r  <= mode_strap_i[1:0];
      lay_r <= string_layout_strap_i;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_ans;
    $rose(penable) && psel && ce_i |=> pready;
  endproperty
  a_ans: assert property (p_ans) else $error("no ready after access");
  property p_pulse;
    pready && ce_i |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_addr;
    $rose(init_done_o) |-> serial_addr_o ==
      (mode_strap_i[2] ? ADDR_LOW : ADDR_HIGH);
  endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_hold;
    init_done_o && $past(init_done_o) |-> $stable(serial_addr_o);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_pre;
    !init_done_o |-> led_gate_o == '0 && current_scale_o == '0;
  endproperty
  a_pre: assert property (p_pre) else $error("output before init");
  property p_dir;
    (init_done_o && md_r == 2'h3 && !pwm_in_i) [*6] |=> led_gate_o == '0;
  endproperty
  a_dir: assert property (p_dir) else $error("gate without input");
  property p_lay;
    init_done_o && lay_r < 3'h5 |-> (led_gate_o >> (3'h6 - lay_r)) == '0;
  endproperty
  a_lay: assert property (p_lay) else $error("unused output on");
  property p_frz;
    !ce_i |=> $stable(led_gate_o) && $stable(pready)
      && $stable(current_scale_o);
  endproperty
  a_frz: assert property (p_frz) else $error("moved while frozen");
  c_err: cover property (pslverr);
  c_init: cover property ($rose(init_done_o));
  c_dir: cover property (md_r == 2'h3 && led_gate_o == 6'h3f);
endmodule
`default_nettype wire

/* test/lbd_host_pwm.sv */
// Purpose: host PWM source feeding the brightness input
// Assumes: on time below period
// Notes:   pin held low while disabled
`timescale 1ns/1ps
`default_nettype none
module lbd_host_pwm (
  input  wire logic        clock_i, // clock
  input  wire logic        en_i,    // run
  input  wire logic [15:0] per_i,   // period, cycles
  input  wire logic [15:0] on_i,    // high time, cycles
  output logic             pwm_o    // pin
);
  logic [15:0] cnt_r = 16'h0;
  initial pwm_o = 1'b0;
  always @(posedge clock_i) begin
    cnt_r <= (cnt_r + 16'h1 >= per_i) ? 16'h0 : cnt_r + 16'h1;
    pwm_o <= en_i && cnt_r < on_i;
  end
endmodule
`default_nettype wire

/* test/test_lbd_core.sv */
// Purpose: self-checking bench for lbd_core
// Assumes: host PWM model drives pwm_in_i
// Notes:   one reset per strap setting
`timescale 1ns/1ps
`default_nettype none
module test_lbd_core;
  logic        clock_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, en = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, pwm_in_i, init_done_o, er;
  logic [2:0]  ms = 3'h0, fs = 3'h0, ls = 3'h0;
  logic [5:0]  led_gate_o;
  logic [11:0] current_scale_o;
  logic [6:0]  serial_addr_o;
  logic [15:0] per = 16'h07d0, on = 16'h03e8;
  logic [31:0] rv [4] = '{32'h2, 32'h3, 32'h0, 32'h0};
  int          n_fail = 0, n_tests = 0, hi;
  always #4 clock_i = ~clock_i;
  lbd_core i_dut (.clock_i, .rst_n_i, .ce_i, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .pwm_in_i,
    .mode_strap_i(ms), .led_freq_strap_i(fs), .string_layout_strap_i(ls),
    .led_gate_o, .current_scale_o, .serial_addr_o, .init_done_o);
  lbd_host_pwm i_host (.clock_i, .en_i(en), .per_i(per), .on_i(on),
    .pwm_o(pwm_in_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock_i);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic boot(input logic [2:0] m, f, l);
    rst_n_i <= 1'b0;
    {ms, fs, ls} <= {m, f, l};
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    while (init_done_o !== 1'b1) begin
      @(posedge clock_i);
    end
    chk(serial_addr_o, m[2] ? 7'h2a : 7'h2b);
  endtask
  // gate 0 high cycles over one 6400-cycle period
  task automatic duty(input int exp);
    hi = 0;
    repeat (12800) @(posedge clock_i);
    repeat (6400) begin
      @(posedge clock_i);
      hi += led_gate_o[0];
    end
    chk(hi > exp - 40 && hi < exp + 40, 1);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #800_000;
    n_fail++;
    close_out;
  end
  initial begin
    for (int i = 0; i < 8; i++) begin
      boot(3'(i), 3'(i), 3'(i));
      apb(1'b0, 8'h10, 32'h0);
      chk(rd[25:16], {1'b1, i[1:0], i[2], i[2:0], i[2:0]});
      {ms, fs, ls} <= ~{ms, fs, ls};
      repeat (20) @(posedge clock_i);
      chk(serial_addr_o, i[2] ? 7'h2a : 7'h2b);
    end
    for (int j = 0; j < 4; j++) begin
      apb(1'b0, 8'(4 * j), 32'h0);
      chk(rd, rv[j]);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk(er, 1'b1);
    wr(8'h0c, 32'hffff_1234);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h1234);
    {per, on, en} <= {16'h0190, 16'h00c8, 1'b1};
    ce_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    ce_i <= 1'b1;
    @(posedge pwm_in_i);
    repeat (8) @(posedge clock_i);
    chk(led_gate_o, 6'h3f);
    @(negedge pwm_in_i);
    repeat (8) @(posedge clock_i);
    chk(led_gate_o, 6'h00);
    boot(3'h0, 3'h7, 3'h0);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h0);
    wr(8'h0c, 32'h7fff);
    wr(8'h08, 32'h1);
    duty(3200);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd[15:0], 16'h7fff);
    wr(8'h04, 32'h1);
    wr(8'h0c, 32'h80ff);
    repeat (2000) @(posedge clock_i);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd[15:0] > 16'h7fff && rd[15:0] < 16'h80ff, 1);
    hi = rd[15:0];
    wr(8'h0c, 32'h7f00);
    repeat (2000) @(posedge clock_i);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd[15:0] < hi && rd[15:0] > 16'h7f00, 1);
    boot(3'h1, 3'h7, 3'h0);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h0c, 32'h1000);
    duty(3200);
    chk(current_scale_o, 12'h200);
    wr(8'h00, 32'h5);
    duty(6400);
    chk(current_scale_o, 12'h100);
    boot(3'h0, 3'h7, 3'h0);
    wr(8'h04, 32'h0);
    {per, on} <= {16'h07d0, 16'h03e8};
    repeat (8000) @(posedge clock_i);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd[15:0], 16'h8000);
    @(posedge pwm_in_i);
    on <= 16'h05dc;
    repeat (8000) @(posedge clock_i);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd[15:0], 16'h8000);
    @(posedge pwm_in_i);
    on <= 16'h076c;
    repeat (8000) @(posedge clock_i);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd[15:0], 16'hf333);
    close_out;
  end
endmodule
bind lbd_core lbd_core_chk i_chk (.*);
`default_nettype wire
